// ---- cop_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module cop_chk (
	// Clock, reset and node setup
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	input wire logic [6:0]           node_addr,
	input wire cop_pkg::cop_nmt_type nmt_state,
	// Link
	input wire logic                 m_valid,
	input wire logic [10:0]          m_id,
	input wire logic [3:0]           m_len,
	input wire logic [63:0]          m_data,
	input wire logic                 n_valid,
	input wire logic [10:0]          n_id,
	input wire logic [3:0]           n_len,
	input wire logic [63:0]          n_data
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] cmd;
	logic       sdo;
	logic       rsp;
	assign cmd = m_data[7:0];
	assign sdo = m_valid && m_id == cop_pkg::COP_SDO_RX_BASE + {4'h0, node_addr} && m_len == 4'h8
		&& node_addr != 7'h00 && nmt_state inside {cop_pkg::COP_NMT_PREOP, cop_pkg::COP_NMT_OPER};
	assign rsp = n_valid && n_id == cop_pkg::COP_SDO_TX_BASE + {4'h0, node_addr};

	chk_sdo_reply: assert property (sdo && cmd != 8'h80 |=> rsp && n_len == 4'h8)
		else $error("Request got no reply");
	chk_echo_addr: assert property (sdo && cmd != 8'h80 |=> n_data[31:8] == $past(m_data[31:8]))
		else $error("Reply does not echo index");
	chk_write_ack: assert property (sdo && cmd inside {8'h23, 8'h2B, 8'h2F} && m_data[31:8] == 24'h00_2000
		|=> n_data[7:0] == 8'h60 && n_data[63:32] == 32'h0000_0000)
		else $error("Write not acknowledged");
	chk_read_code: assert property (sdo && cmd == 8'h40
		|=> n_data[7:0] inside {8'h43, 8'h4B, 8'h4F, 8'h80})
		else $error("Bad read reply code");
	chk_bad_cmd: assert property (sdo && !(cmd inside {8'h23, 8'h2B, 8'h2F, 8'h40, 8'h80})
		|=> n_data[7:0] == 8'h80 && n_data[63:32] == cop_pkg::COP_ABT_CMD)
		else $error("Bad command not aborted");
	chk_abort_quiet: assert property (sdo && cmd == 8'h80 |=> !rsp)
		else $error("Abort was answered");
	chk_pdo_silent: assert property (m_valid && m_id == 11'h201 |=> !rsp)
		else $error("Received PDO was answered");
	chk_foreign_req: assert property (m_valid && m_id[10:7] == 4'hC
		&& (m_id[6:0] != node_addr || nmt_state == cop_pkg::COP_NMT_STOP) |=> !rsp)
		else $error("Foreign or stopped request answered");
	chk_tpdo_len: assert property (n_valid && n_id == 11'h181 |-> n_len == 4'h3)
		else $error("Transmit PDO length wrong");
endmodule
`default_nettype wire

// ---- cop_client.sv ----
`timescale 1ns/1ns
`default_nettype none
module cop_client (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Frame link
	cop_if.client            link
);

	typedef struct packed {
		logic [10:0] tx_id;
		logic [3:0]  tx_len;
		logic [63:0] tx_data;
		logic        send;
		logic [10:0] rx_id;
		logic [3:0]  rx_len;
		logic [63:0] rx_data;
		logic        rx_new;
		logic        rx_ovr;
		logic [31:0] rdata;
	} cop_client_state_type;

	cop_client_state_type state_reg;
	cop_client_state_type state_next;

	logic mapped;
	logic wr;
	logic w1c_new;
	logic w1c_ovr;

	assign mapped  = paddr <= cop_pkg::COP_R_STATUS && paddr[1:0] == 2'b00;
	assign wr      = psel && penable && pwrite && mapped;
	assign w1c_new = wr && paddr == cop_pkg::COP_R_STATUS && pwdata[0];
	assign w1c_ovr = wr && paddr == cop_pkg::COP_R_STATUS && pwdata[1];

	// ==========================================================
	// Registers and frame capture
	always_comb begin
		state_next      = state_reg;
		state_next.send = 1'b0;
		if (wr) begin
			case (paddr)
				cop_pkg::COP_R_TX_ID:  state_next.tx_id = pwdata[10:0];
				cop_pkg::COP_R_TX_LEN: state_next.tx_len = pwdata[3:0];
				cop_pkg::COP_R_TX_LO:  state_next.tx_data[31:0] = pwdata;
				cop_pkg::COP_R_TX_HI:  state_next.tx_data[63:32] = pwdata;
				// Frame content is software's; PDOs get no automatic reply
				cop_pkg::COP_R_SEND:   state_next.send = 1'b1;
				default:               state_next.send = 1'b0;
			endcase
		end
		if (w1c_new) begin
			state_next.rx_new = 1'b0;
		end
		if (w1c_ovr) begin
			state_next.rx_ovr = 1'b0;
		end
		// Capture wins over a clear in the same cycle
		if (link.n_valid) begin
			state_next.rx_id   = link.n_id;
			state_next.rx_len  = link.n_len;
			state_next.rx_data = link.n_data;
			state_next.rx_new  = 1'b1;
			if (state_reg.rx_new && !w1c_new) begin
				state_next.rx_ovr = 1'b1;
			end
		end
		// Read data is taken in the setup cycle
		if (psel && !penable) begin
			case (paddr)
				cop_pkg::COP_R_TX_ID:  state_next.rdata = {21'h0, state_reg.tx_id};
				cop_pkg::COP_R_TX_LEN: state_next.rdata = {28'h0, state_reg.tx_len};
				cop_pkg::COP_R_TX_LO:  state_next.rdata = state_reg.tx_data[31:0];
				cop_pkg::COP_R_TX_HI:  state_next.rdata = state_reg.tx_data[63:32];
				cop_pkg::COP_R_RX_ID:  state_next.rdata = {21'h0, state_reg.rx_id};
				cop_pkg::COP_R_RX_LEN: state_next.rdata = {28'h0, state_reg.rx_len};
				cop_pkg::COP_R_RX_LO:  state_next.rdata = state_reg.rx_data[31:0];
				cop_pkg::COP_R_RX_HI:  state_next.rdata = state_reg.rx_data[63:32];
				cop_pkg::COP_R_STATUS: state_next.rdata = {30'h0, state_reg.rx_ovr, state_reg.rx_new};
				default:               state_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata       = state_reg.rdata;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign link.m_valid = state_reg.send;
	assign link.m_id    = state_reg.tx_id;
	assign link.m_len   = state_reg.tx_len;
	assign link.m_data  = state_reg.tx_data;

endmodule
`default_nettype wire

// ---- cop_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface cop_if;
	// Frames from client to node
	logic        m_valid;
	logic [10:0] m_id;
	logic [3:0]  m_len;
	logic [63:0] m_data;
	// Frames from node to client
	logic        n_valid;
	logic [10:0] n_id;
	logic [3:0]  n_len;
	logic [63:0] n_data;

	modport node (input m_valid, m_id, m_len, m_data, output n_valid, n_id, n_len, n_data);
	modport client (output m_valid, m_id, m_len, m_data, input n_valid, n_id, n_len, n_data);
endinterface
`default_nettype wire

// ---- cop_node.sv ----
`timescale 1ns/1ns
`default_nettype none
module cop_node #(
	parameter int TICK_CYC = cop_pkg::COP_TICK_CYC
) (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// Frame link
	cop_if.node                      link,
	// Node configuration
	input  wire logic [6:0]          node_addr,
	input  wire cop_pkg::cop_nmt_type nmt_state,
	// Application side
	input  wire logic                app_in_valid,
	input  wire logic [15:0]         app_in,
	input  wire logic                pdo_trigger,
	output logic      [31:0]         app_out,
	output logic                     rpdo_strobe,
	output logic                     sdo_abort_seen
);

	typedef struct packed {
		logic [cop_pkg::COP_NSLOT-1:0][31:0] od;
		logic                                tx_valid;
		logic [10:0]                         tx_id;
		logic [3:0]                          tx_len;
		logic [63:0]                         tx_data;
		logic [63:0]                         last_sent;
		logic [7:0]                          sync_cnt;
		logic [15:0]                         inh_cnt;
		logic [19:0]                         evt_cnt;
		logic [15:0]                         div_cnt;
		logic                                pend;
		logic                                rpdo_stb;
		logic                                abort_stb;
	} cop_node_state_type;

	cop_node_state_type state_reg;
	cop_node_state_type state_next;

	// ==========================================================
	// Dictionary decode
	function automatic logic [4:0] cop_lookup(input logic [15:0] idx, input logic [7:0] sub);
		logic [4:0] r;
		r = 5'h00;
		case ({idx, sub})
			24'h2000_00: r = {1'b1, cop_pkg::COP_S_APP_OUT};
			24'h2001_00: r = {1'b1, cop_pkg::COP_S_APP_IN};
			24'h2002_00: r = {1'b1, cop_pkg::COP_S_APP_B};
			24'h1400_01: r = {1'b1, cop_pkg::COP_S_RPDO_ID};
			24'h1800_01: r = {1'b1, cop_pkg::COP_S_TPDO_ID};
			24'h1800_02: r = {1'b1, cop_pkg::COP_S_TTYPE};
			24'h1800_03: r = {1'b1, cop_pkg::COP_S_INHIBIT};
			24'h1800_05: r = {1'b1, cop_pkg::COP_S_EVTIME};
			24'h1A00_00: r = {1'b1, cop_pkg::COP_S_MAP_N};
			24'h1A00_01: r = {1'b1, cop_pkg::COP_S_MAP1};
			24'h1A00_02: r = {1'b1, cop_pkg::COP_S_MAP2};
			default:     r = 5'h00;
		endcase
		return r;
	endfunction

	// Object width in bytes: 4, 2 or 1
	function automatic logic [2:0] cop_width(input logic [3:0] slot);
		logic [2:0] w;
		w = 3'h4;
		case (slot)
			cop_pkg::COP_S_APP_IN, cop_pkg::COP_S_INHIBIT, cop_pkg::COP_S_EVTIME: w = 3'h2;
			cop_pkg::COP_S_APP_B, cop_pkg::COP_S_TTYPE, cop_pkg::COP_S_MAP_N: w = 3'h1;
			default: w = 3'h4;
		endcase
		return w;
	endfunction

	function automatic logic [31:0] cop_bmask(input logic [2:0] nbytes);
		logic [31:0] m;
		m = 32'h0000_0000;
		case (nbytes)
			3'h1:    m = 32'h0000_00FF;
			3'h2:    m = 32'h0000_FFFF;
			default: m = 32'hFFFF_FFFF;
		endcase
		return m;
	endfunction

	// ==========================================================
	// Request decode
	logic        addr_ok;
	logic        rx;
	logic        sdo_ok;
	logic        pdo_ok;
	logic        sdo_req;
	logic        rpdo_req;
	logic        sync_req;
	logic [7:0]  cmd;
	logic [15:0] idx;
	logic [7:0]  sub;
	logic [31:0] wdata;
	logic [4:0]  obj;
	logic [31:0] omask;
	logic [31:0] wmask;

	assign addr_ok  = node_addr != 7'h00;
	assign rx       = link.m_valid && addr_ok;
	assign sdo_ok   = nmt_state == cop_pkg::COP_NMT_PREOP || nmt_state == cop_pkg::COP_NMT_OPER;
	assign pdo_ok   = nmt_state == cop_pkg::COP_NMT_OPER;
	assign sdo_req  = rx && sdo_ok && link.m_len == cop_pkg::COP_SDO_LEN
		&& link.m_id == cop_pkg::COP_SDO_RX_BASE + {4'h0, node_addr};
	assign rpdo_req = rx && pdo_ok && link.m_len != 4'h0
		&& link.m_id == state_reg.od[cop_pkg::COP_S_RPDO_ID][10:0];
	assign sync_req = rx && pdo_ok && link.m_id == cop_pkg::COP_SYNC_ID;
	assign cmd      = link.m_data[7:0];
	assign idx      = link.m_data[23:8];
	assign sub      = link.m_data[31:24];
	assign wdata    = link.m_data[63:32];
	assign obj      = cop_lookup(idx, sub);
	assign omask    = cop_bmask(cop_width(obj[3:0]));
	assign wmask    = cmd == cop_pkg::COP_CMD_WR4 ? cop_bmask(3'h4)
		: cmd == cop_pkg::COP_CMD_WR2 ? cop_bmask(3'h2) : cop_bmask(3'h1);

	// ==========================================================
	// Transmit PDO packing
	logic [31:0] map1;
	logic [31:0] map2;
	logic [4:0]  obj1;
	logic [4:0]  obj2;
	logic [7:0]  bits1;
	logic [7:0]  bits2;
	logic [63:0] v1;
	logic [63:0] v2;
	logic [63:0] payload;
	logic [7:0]  nbits;
	logic [3:0]  plen;

	assign map1  = state_reg.od[cop_pkg::COP_S_MAP1];
	assign map2  = state_reg.od[cop_pkg::COP_S_MAP2];
	assign obj1  = cop_lookup(map1[31:16], map1[15:8]);
	assign obj2  = cop_lookup(map2[31:16], map2[15:8]);
	// Entries other than 8, 16 or 32 bits are skipped rather than sliced
	assign bits1 = (obj1[4] && state_reg.od[cop_pkg::COP_S_MAP_N][7:0] >= 8'h01
		&& (map1[7:0] == 8'd8 || map1[7:0] == 8'd16 || map1[7:0] == 8'd32)) ? map1[7:0] : 8'h00;
	assign bits2 = (obj2[4] && state_reg.od[cop_pkg::COP_S_MAP_N][7:0] >= 8'h02
		&& (map2[7:0] == 8'd8 || map2[7:0] == 8'd16 || map2[7:0] == 8'd32)) ? map2[7:0] : 8'h00;
	assign v1    = {32'h0000_0000, state_reg.od[obj1[3:0]] & cop_bmask(3'(bits1 >> 3))};
	assign v2    = {32'h0000_0000, state_reg.od[obj2[3:0]] & cop_bmask(3'(bits2 >> 3))};
	assign payload = (bits1 == 8'h00 ? 64'h0 : v1) | (bits2 == 8'h00 ? 64'h0 : v2 << bits1);
	assign nbits = bits1 + bits2;
	assign plen  = 4'(nbits >> 3);

	// ==========================================================
	// Next state
	logic        tick;
	logic        changed;
	logic        evt_due;
	logic [7:0]  ttype;
	logic [19:0] evt_lim;

	assign tick    = state_reg.div_cnt == 16'(TICK_CYC - 1);
	assign changed = payload != state_reg.last_sent;
	assign ttype   = state_reg.od[cop_pkg::COP_S_TTYPE][7:0];
	assign evt_lim = 20'(state_reg.od[cop_pkg::COP_S_EVTIME][15:0]) * 20'(cop_pkg::COP_TICKS_MS);
	assign evt_due = evt_lim != 20'h0 && state_reg.evt_cnt >= evt_lim;

	always_comb begin
		state_next           = state_reg;
		state_next.tx_valid  = 1'b0;
		state_next.rpdo_stb  = 1'b0;
		state_next.abort_stb = 1'b0;
		state_next.div_cnt   = tick ? 16'h0000 : state_reg.div_cnt + 16'h0001;
		if (tick && state_reg.inh_cnt != 16'h0000) begin
			state_next.inh_cnt = state_reg.inh_cnt - 16'h0001;
		end
		if (tick && !evt_due) begin
			state_next.evt_cnt = state_reg.evt_cnt + 20'h00001;
		end
		if (app_in_valid) begin
			state_next.od[cop_pkg::COP_S_APP_IN] = {16'h0000, app_in};
		end
		// Received PDO fills the output object, no answer goes back
		if (rpdo_req) begin
			state_next.od[cop_pkg::COP_S_APP_OUT] = link.m_data[31:0];
			state_next.rpdo_stb = 1'b1;
		end
		// Transmit PDO triggers
		if (!pdo_ok) begin
			state_next.pend = 1'b0;
		end else if (ttype == cop_pkg::COP_TT_ACYC) begin
			if (sync_req && changed) begin
				state_next.pend = 1'b1;
			end
		end else if (ttype <= cop_pkg::COP_TT_CYC_MAX) begin
			if (sync_req) begin
				if (state_reg.sync_cnt + 8'h01 >= ttype) begin
					state_next.sync_cnt = 8'h00;
					state_next.pend = 1'b1;
				end else begin
					state_next.sync_cnt = state_reg.sync_cnt + 8'h01;
				end
			end
		end else if (ttype == cop_pkg::COP_TT_MFR || ttype == cop_pkg::COP_TT_ASYNC) begin
			if ((changed || pdo_trigger || evt_due) && state_reg.inh_cnt == 16'h0000) begin
				state_next.pend = 1'b1;
			end
		end
		// SDO server; a reply takes the transmitter before a pending PDO
		if (sdo_req) begin
			state_next.tx_id   = cop_pkg::COP_SDO_TX_BASE + {4'h0, node_addr};
			state_next.tx_len  = cop_pkg::COP_SDO_LEN;
			state_next.tx_data = {32'h0000_0000, sub, idx, cop_pkg::COP_CMD_ABORT};
			state_next.tx_valid = 1'b1;
			case (cmd)
				cop_pkg::COP_CMD_WR4, cop_pkg::COP_CMD_WR2, cop_pkg::COP_CMD_WR1: begin
					if (obj[4]) begin
						state_next.od[obj[3:0]] = (state_reg.od[obj[3:0]] & ~(wmask & omask))
							| (wdata & wmask & omask);
						state_next.tx_data[7:0] = cop_pkg::COP_RSP_WR;
					end else begin
						state_next.tx_data[63:32] = cop_pkg::COP_ABT_NOOBJ;
					end
				end
				cop_pkg::COP_CMD_RD: begin
					if (obj[4]) begin
						state_next.tx_data[63:32] = state_reg.od[obj[3:0]] & omask;
						case (cop_width(obj[3:0]))
							3'h1:    state_next.tx_data[7:0] = cop_pkg::COP_RSP_RD1;
							3'h2:    state_next.tx_data[7:0] = cop_pkg::COP_RSP_RD2;
							default: state_next.tx_data[7:0] = cop_pkg::COP_RSP_RD4;
						endcase
					end else begin
						state_next.tx_data[63:32] = cop_pkg::COP_ABT_NOOBJ;
					end
				end
				cop_pkg::COP_CMD_ABORT: begin
					state_next.tx_valid  = 1'b0;
					state_next.abort_stb = 1'b1;
				end
				default: begin
					// Segmented transfers are not served and are aborted here
					state_next.tx_data[63:32] = cop_pkg::COP_ABT_CMD;
				end
			endcase
		end
		if (state_next.pend && !state_next.tx_valid) begin
			state_next.tx_valid  = 1'b1;
			state_next.tx_id     = state_reg.od[cop_pkg::COP_S_TPDO_ID][10:0];
			state_next.tx_len    = plen == 4'h0 ? 4'h1 : plen;
			state_next.tx_data   = payload;
			state_next.last_sent = payload;
			state_next.inh_cnt   = state_reg.od[cop_pkg::COP_S_INHIBIT][15:0];
			state_next.evt_cnt   = 20'h00000;
			state_next.pend      = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.od[cop_pkg::COP_S_RPDO_ID] <= cop_pkg::COP_RPDO_ID_RST;
			state_reg.od[cop_pkg::COP_S_TPDO_ID] <= cop_pkg::COP_TPDO_ID_RST;
			state_reg.od[cop_pkg::COP_S_TTYPE]   <= cop_pkg::COP_TTYPE_RST;
			state_reg.od[cop_pkg::COP_S_MAP_N]   <= cop_pkg::COP_MAP_N_RST;
			state_reg.od[cop_pkg::COP_S_MAP1]    <= cop_pkg::COP_MAP1_RST;
			state_reg.od[cop_pkg::COP_S_MAP2]    <= cop_pkg::COP_MAP2_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Outputs
	assign link.n_valid   = state_reg.tx_valid;
	assign link.n_id      = state_reg.tx_id;
	assign link.n_len     = state_reg.tx_len;
	assign link.n_data    = state_reg.tx_data;
	assign app_out        = state_reg.od[cop_pkg::COP_S_APP_OUT];
	assign rpdo_strobe    = state_reg.rpdo_stb;
	assign sdo_abort_seen = state_reg.abort_stb;

endmodule
`default_nettype wire

// ---- cop_pkg.sv ----
package cop_pkg;

	// ==========================================================
	// Frame identifiers and SDO command codes
	localparam logic [10:0] COP_SDO_RX_BASE = 11'h600;
	localparam logic [10:0] COP_SDO_TX_BASE = 11'h580;
	localparam logic [10:0] COP_SYNC_ID     = 11'h080;
	localparam logic [7:0]  COP_CMD_WR4     = 8'h23;
	localparam logic [7:0]  COP_CMD_WR2     = 8'h2B;
	localparam logic [7:0]  COP_CMD_WR1     = 8'h2F;
	localparam logic [7:0]  COP_CMD_RD      = 8'h40;
	localparam logic [7:0]  COP_CMD_ABORT   = 8'h80;
	localparam logic [7:0]  COP_RSP_RD4     = 8'h43;
	localparam logic [7:0]  COP_RSP_RD2     = 8'h4B;
	localparam logic [7:0]  COP_RSP_RD1     = 8'h4F;
	localparam logic [7:0]  COP_RSP_WR      = 8'h60;
	localparam logic [31:0] COP_ABT_CMD     = 32'h0504_0001;
	localparam logic [31:0] COP_ABT_NOOBJ   = 32'h0602_0000;
	localparam logic [3:0]  COP_SDO_LEN     = 4'h8;

	// ==========================================================
	// Dictionary slots
	localparam int         COP_NSLOT     = 11;
	localparam logic [3:0] COP_S_APP_OUT = 4'h0;
	localparam logic [3:0] COP_S_APP_IN  = 4'h1;
	localparam logic [3:0] COP_S_APP_B   = 4'h2;
	localparam logic [3:0] COP_S_RPDO_ID = 4'h3;
	localparam logic [3:0] COP_S_TPDO_ID = 4'h4;
	localparam logic [3:0] COP_S_TTYPE   = 4'h5;
	localparam logic [3:0] COP_S_INHIBIT = 4'h6;
	localparam logic [3:0] COP_S_EVTIME  = 4'h7;
	localparam logic [3:0] COP_S_MAP_N   = 4'h8;
	localparam logic [3:0] COP_S_MAP1    = 4'h9;
	localparam logic [3:0] COP_S_MAP2    = 4'hA;

	// Reset values of dictionary slots
	localparam logic [31:0] COP_RPDO_ID_RST = 32'h0000_0201;
	localparam logic [31:0] COP_TPDO_ID_RST = 32'h0000_0181;
	localparam logic [31:0] COP_TTYPE_RST   = 32'h0000_00FF;
	localparam logic [31:0] COP_MAP_N_RST   = 32'h0000_0002;
	localparam logic [31:0] COP_MAP1_RST    = 32'h2001_0010;
	localparam logic [31:0] COP_MAP2_RST    = 32'h2002_0008;

	// ==========================================================
	// Transmission types and timing
	localparam logic [7:0] COP_TT_ACYC    = 8'h00;
	localparam logic [7:0] COP_TT_CYC_MAX = 8'hF0;
	localparam logic [7:0] COP_TT_MFR     = 8'hFE;
	localparam logic [7:0] COP_TT_ASYNC   = 8'hFF;
	localparam int         COP_CLK_MHZ    = 100;
	localparam int         COP_TICK_US    = 100;
	localparam int         COP_TICK_CYC   = COP_TICK_US * COP_CLK_MHZ;
	localparam int         COP_TICKS_MS   = 1000 / COP_TICK_US;

	typedef enum logic [1:0] {
		COP_NMT_INIT  = 2'b00,
		COP_NMT_PREOP = 2'b01,
		COP_NMT_OPER  = 2'b10,
		COP_NMT_STOP  = 2'b11
	} cop_nmt_type;

	// ==========================================================
	// Client register offsets
	localparam logic [7:0] COP_R_TX_ID  = 8'h00;
	localparam logic [7:0] COP_R_TX_LEN = 8'h04;
	localparam logic [7:0] COP_R_TX_LO  = 8'h08;
	localparam logic [7:0] COP_R_TX_HI  = 8'h0C;
	localparam logic [7:0] COP_R_SEND   = 8'h10;
	localparam logic [7:0] COP_R_RX_ID  = 8'h14;
	localparam logic [7:0] COP_R_RX_LEN = 8'h18;
	localparam logic [7:0] COP_R_RX_LO  = 8'h1C;
	localparam logic [7:0] COP_R_RX_HI  = 8'h20;
	localparam logic [7:0] COP_R_STATUS = 8'h24;

endpackage

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	// ==========================================================
	// Signals
	localparam logic [10:0] NODE = 11'h005;
	logic                 core_clk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, rdat, rid, rlen, app_out;
	logic [63:0]          rdata;
	logic                 app_in_valid, pdo_trigger, rpdo_strobe, sdo_abort_seen;
	logic [15:0]          app_in;
	logic [6:0]           node_addr;
	cop_pkg::cop_nmt_type nmt;
	int                   errors, cmp_count, nstb, nabt;
	cop_if link();
	cop_node #(.TICK_CYC(10)) u_cop_node (.core_clk(core_clk), .rst_n(rst_n), .link(link),
		.node_addr(node_addr), .nmt_state(nmt), .app_in_valid(app_in_valid), .app_in(app_in),
		.pdo_trigger(pdo_trigger), .app_out(app_out), .rpdo_strobe(rpdo_strobe),
		.sdo_abort_seen(sdo_abort_seen));
	cop_client u_cop_client (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	cop_chk u_cop_chk (.core_clk(core_clk), .rst_n(rst_n), .node_addr(node_addr),
		.nmt_state(nmt), .m_valid(link.m_valid), .m_id(link.m_id), .m_len(link.m_len),
		.m_data(link.m_data), .n_valid(link.n_valid), .n_id(link.n_id), .n_len(link.n_len),
		.n_data(link.n_data));

	// ==========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic send(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
		apb(1'b1, cop_pkg::COP_R_TX_ID, {21'h0, id});
		apb(1'b1, cop_pkg::COP_R_TX_LEN, {28'h0, len});
		apb(1'b1, cop_pkg::COP_R_TX_LO, d[31:0]);
		apb(1'b1, cop_pkg::COP_R_TX_HI, d[63:32]);
		apb(1'b1, cop_pkg::COP_R_SEND, 32'h0000_0000);
	endtask
	// Fetches one frame seen by the client, then clears its flag
	task automatic get(input string nm);
		int n;
		n = 0;
		do begin
			apb(1'b0, cop_pkg::COP_R_STATUS, 32'h0);
			n++;
		end while (rdat[0] !== 1'b1 && n < 40);
		check(nm, rdat[0], 1'b1);
		apb(1'b0, cop_pkg::COP_R_RX_ID, 32'h0); rid = rdat;
		apb(1'b0, cop_pkg::COP_R_RX_LEN, 32'h0); rlen = rdat;
		apb(1'b0, cop_pkg::COP_R_RX_LO, 32'h0); rdata[31:0] = rdat;
		apb(1'b0, cop_pkg::COP_R_RX_HI, 32'h0); rdata[63:32] = rdat;
		apb(1'b1, cop_pkg::COP_R_STATUS, 32'h0000_0003);
	endtask
	task automatic quiet(input string nm);
		repeat (10) @(posedge core_clk);
		apb(1'b0, cop_pkg::COP_R_STATUS, 32'h0);
		check(nm, rdat[0], 1'b0);
	endtask
	task automatic sdo_io(input logic [7:0] c, input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] d, input logic [7:0] rc, input logic [31:0] rv);
		send(cop_pkg::COP_SDO_RX_BASE + NODE, 4'h8, {d, sb, ix, c});
		get("sdo reply");
		check("reply id", {rid[10:0], rlen[3:0]}, {cop_pkg::COP_SDO_TX_BASE + NODE, 4'h8});
		check("reply data", rdata, {rv, sb, ix, rc});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		apb(1'b0, cop_pkg::COP_R_STATUS, 32'h0); check("status reset", rdat, 32'h0);
		apb(1'b0, 8'h28, 32'h0); check("unmapped", {perr, rdat}, {1'b1, 32'h0});
		$display("test regs done");
	endtask
	task automatic t_sdo;
		sdo_io(8'h23, 16'h2000, 8'h00, 32'hAABB_CCDD, 8'h60, 32'h0);
		sdo_io(8'h2B, 16'h2000, 8'h00, 32'h1234_1122, 8'h60, 32'h0);
		check("wr2", app_out, 32'hAABB_1122);
		sdo_io(8'h2F, 16'h2000, 8'h00, 32'h5566_7733, 8'h60, 32'h0);
		check("wr1", app_out, 32'hAABB_1133);
		sdo_io(8'h2F, 16'h2002, 8'h00, 32'h0000_0033, 8'h60, 32'h0);
		sdo_io(8'h40, 16'h2000, 8'h00, 32'h0, 8'h43, 32'hAABB_1133);
		sdo_io(8'h40, 16'h2001, 8'h00, 32'h0, 8'h4B, 32'h0);
		sdo_io(8'h40, 16'h2002, 8'h00, 32'h0, 8'h4F, 32'h33);
		$display("test sdo done");
	endtask
	task automatic t_abort;
		int n;
		n = nabt;
		sdo_io(8'h21, 16'h2000, 8'h00, 32'h0, 8'h80, cop_pkg::COP_ABT_CMD);
		sdo_io(8'h40, 16'h3000, 8'h00, 32'h0, 8'h80, cop_pkg::COP_ABT_NOOBJ);
		sdo_io(8'h40, 16'h2000, 8'h01, 32'h0, 8'h80, cop_pkg::COP_ABT_NOOBJ);
		send(cop_pkg::COP_SDO_RX_BASE + NODE, 4'h8, {56'h0, 8'h80});
		quiet("abort silent");
		check("abort seen", nabt, n + 1);
		$display("test abort done");
	endtask
	task automatic t_filter;
		send(cop_pkg::COP_SDO_RX_BASE + NODE + 11'h1, 4'h8, {40'h0, 16'h2000, 8'h40});
		quiet("other node");
		node_addr <= 7'h00;
		send(cop_pkg::COP_SDO_RX_BASE, 4'h8, {40'h0, 16'h2000, 8'h40});
		quiet("address zero");
		node_addr <= NODE[6:0];
		nmt <= cop_pkg::COP_NMT_STOP;
		send(cop_pkg::COP_SDO_RX_BASE + NODE, 4'h8, {40'h0, 16'h2000, 8'h40});
		quiet("stopped");
		$display("test filter done");
	endtask
	task automatic t_pdo;
		int n;
		nmt <= cop_pkg::COP_NMT_OPER;
		repeat (30) @(posedge core_clk);
		apb(1'b1, cop_pkg::COP_R_STATUS, 32'h0000_0003);
		n = nstb;
		send(11'h201, 4'h4, 64'h0000_0000_5566_7788);
		quiet("rpdo silent");
		check("rpdo data", {app_out, nstb}, {32'h5566_7788, n + 1});
		send(11'h202, 4'h4, 64'h0000_0000_0102_0304);
		quiet("foreign pdo");
		check("foreign data", app_out, 32'h5566_7788);
		app_in <= 16'hBEEF; app_in_valid <= 1'b1;
		@(posedge core_clk);
		app_in_valid <= 1'b0;
		get("tpdo change");
		check("tpdo", {rid[10:0], rlen[3:0], rdata[23:0]}, {11'h181, 4'h3, 24'h33_BEEF});
		pdo_trigger <= 1'b1;
		@(posedge core_clk);
		pdo_trigger <= 1'b0;
		get("tpdo trig");
		check("trig", {rid[10:0], rdata[23:0]}, {11'h181, 24'h33_BEEF});
		sdo_io(8'h2F, 16'h1800, 8'h02, 32'h2, 8'h60, 32'h0);
		send(cop_pkg::COP_SYNC_ID, 4'h0, 64'h0);
		quiet("sync one");
		send(cop_pkg::COP_SYNC_ID, 4'h0, 64'h0);
		get("sync two");
		check("sync tpdo", {rid[10:0], rdata[23:0]}, {11'h181, 24'h33_BEEF});
		sdo_io(8'h2F, 16'h1800, 8'h02, 32'h0, 8'h60, 32'h0);
		send(cop_pkg::COP_SYNC_ID, 4'h0, 64'h0);
		quiet("sync unchanged");
		app_in <= 16'hCAFE; app_in_valid <= 1'b1;
		@(posedge core_clk);
		app_in_valid <= 1'b0;
		quiet("change no sync");
		send(cop_pkg::COP_SYNC_ID, 4'h0, 64'h0);
		get("sync changed");
		check("type0 tpdo", {rid[10:0], rdata[23:0]}, {11'h181, 24'h33_CAFE});
		$display("test pdo done");
	endtask

	// ==========================================================
	// Run control
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge core_clk) begin
		if (rpdo_strobe === 1'b1) nstb++;
		if (sdo_abort_seen === 1'b1) nabt++;
	end
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		report_and_stop;
	end
	initial begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; app_in_valid = 1'b0; app_in = 16'h0; pdo_trigger = 1'b0;
		nmt = cop_pkg::COP_NMT_PREOP;
		node_addr = NODE[6:0];
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_sdo;
		t_abort;
		t_filter;
		t_pdo;
		report_and_stop;
	end
endmodule
`default_nettype wire
